// ==== bench/psu_alert_checker.sv ====
// Checker: alert timing and persistence, limit defaults
`timescale 1ns/1ps
module psu_alert_checker (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       vin_ok,
  input wire logic       vin_uv,
  input wire logic       iout_oc_wrn,
  input wire logic       pout_op_wrn,
  input wire logic       power_on_request,
  input wire logic       main_on,
  input wire logic       alert_n_oe,
  input wire logic [7:0] ot_warn_limit,
  input wire logic [7:0] oc_warn_limit
);
  localparam int UV_MAX = 40_000;
  int op_cnt = 0;
  int uv_cnt = 0;
  // ==========================================================
  // Watchers: op_cnt ignores rst, the design can only start later
  always_ff @(posedge mclk) begin
    op_cnt <= pout_op_wrn ? op_cnt + 1 : 0;
    uv_cnt <= (rst || !vin_uv || !main_on || alert_n_oe) ? 0 : uv_cnt + 1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  reset_values_a: assert property ($fell(rst) |-> ot_warn_limit == 8'h64 && !alert_n_oe)
    else $error("bad reset values");
  standby_quiet_a: assert property (!main_on [*4] |-> !alert_n_oe)
    else $error("alert in standby");
  op_min_delay_a: assert property ($rose(alert_n_oe) && pout_op_wrn && !vin_uv && !iout_oc_wrn
    |-> op_cnt >= alert_pkg::OP_CYC - 2)
    else $error("overpower alert too early");
  uv_max_delay_a: assert property (uv_cnt <= UV_MAX)
    else $error("undervoltage alert too late");
  op_hold_a: assert property (alert_n_oe && pout_op_wrn && main_on ##1 main_on && pout_op_wrn
    |-> alert_n_oe)
    else $error("alert dropped during overpower");
  uv_hold_a: assert property (alert_n_oe && vin_uv && main_on ##1 main_on && vin_uv
    |-> alert_n_oe)
    else $error("alert dropped during undervoltage");
  pon_revert_a: assert property ($rose(power_on_request)
    |-> ##[1:6] (ot_warn_limit == 8'h64 && oc_warn_limit == 8'hFF))
    else $error("limits kept after request cycle");
  vin_revert_a: assert property ($rose(vin_ok)
    |-> ##[1:6] (ot_warn_limit == 8'h64 && oc_warn_limit == 8'hFF))
    else $error("limits kept after power cycle");
endmodule : psu_alert_checker
bind psu_alert psu_alert_checker i_chk (.mclk(mclk), .rst(rst), .vin_ok(vin_ok),
  .vin_uv(vin_uv), .iout_oc_wrn(iout_oc_wrn), .pout_op_wrn(pout_op_wrn),
  .power_on_request(power_on_request), .main_on(main_on), .alert_n_oe(alert_n_oe),
  .ot_warn_limit(ot_warn_limit), .oc_warn_limit(oc_warn_limit));

// ==== bench/smbus_host_model.sv ====
// Host model: SMBus master issuing writes with packet error checking
`timescale 1ns/1ps
module smbus_host_model (
  input  wire logic mclk,
  input  wire logic sda_oe,
  output logic      scl_in,
  output logic      sda_in
);
  logic drv_low = 1'b0;
  logic got_ack = 1'b0;
  // Both lines have pull-ups: released SDA and idle SCL read high
  assign sda_in = !(drv_low || sda_oe);
  initial scl_in = 1'b1;
  // CRC-8 with polynomial x^8+x^2+x+1
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) r = {r[6:0], 1'b0} ^ (r[7] ? 8'h07 : 8'h00);
    return r;
  endfunction : crc8
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #5;
  endtask : tick
  // Data moves only while SCL is low; ack is read late in the high phase
  task automatic put_bit(input logic b);
    scl_in = 1'b0;
    tick(1);
    drv_low = !b;
    tick(3);
    scl_in = 1'b1;
    tick(3);
    got_ack = !sda_in;
    tick(1);
  endtask : put_bit
  task automatic put_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    put_bit(1'b1);
  endtask : put_byte
  task automatic xfer(input logic [6:0] addr, input logic [7:0] cmd, input logic [7:0] dat,
                      input logic has_dat, input logic bad_pec, output logic acked);
    logic [7:0] pec;
    pec = crc8(crc8(8'h00, {addr, 1'b0}), cmd);
    if (has_dat) pec = crc8(pec, dat);
    drv_low = 1'b1;
    tick(4);
    put_byte({addr, 1'b0});
    acked = got_ack;
    put_byte(cmd);
    if (has_dat) put_byte(dat);
    put_byte(pec ^ {7'h00, bad_pec});
    scl_in = 1'b0;
    tick(1);
    drv_low = 1'b1;
    tick(3);
    scl_in = 1'b1;
    tick(4);
    drv_low = 1'b0;
    tick(8);
  endtask : xfer
endmodule : smbus_host_model

// ==== bench/test_psu_alert.sv ====
// Testbench: bus writes, alert timing, clearing and limit defaults
`timescale 1ns/1ps
module test_psu_alert;
  logic       mclk = 1'b0, rst = 1'b1, vin_ok = 1'b1, vin_uv = 1'b0, oc_wrn = 1'b0;
  logic       op_wrn = 1'b0, pon = 1'b1, main_on = 1'b0, scl, sda, sda_oe, al, ack;
  logic [7:0] inlet = 8'h20, hot = 8'h30, ot_lim, oc_lim, d;
  int         err_count = 0, check_count = 0, n;
  always #25 mclk = ~mclk;
  psu_alert i_dut (.mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_oe(sda_oe),
    .vin_ok(vin_ok), .vin_uv(vin_uv), .iout_oc_flt(1'b0), .iout_oc_wrn(oc_wrn),
    .pout_op_wrn(op_wrn), .inlet_temp_sensor(inlet), .hotspot_temp_sensor(hot),
    .power_on_request(pon), .main_on(main_on), .alert_n_oe(al),
    .ot_warn_limit(ot_lim), .oc_warn_limit(oc_lim));
  smbus_host_model i_host (.mclk(mclk), .sda_oe(sda_oe), .scl_in(scl), .sda_in(sda));
  // ==========================================================
  // Helpers
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #5;
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] cmd, input logic [7:0] dat, input logic bad = 1'b0);
    i_host.xfer(7'h58, cmd, dat, 1'b1, bad, ack);
  endtask : wr
  task automatic clr();
    i_host.xfer(7'h58, alert_pkg::CMD_CLEAR, 8'h00, 1'b0, 1'b0, ack);
    tick(2);
  endtask : clr
  task automatic wait_al(input int lim);
    n = 0;
    while (al !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
  endtask : wait_al
  task automatic final_report();
    $display("mismatches %0d of %0d checks", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // Watchdog: the sequence needs about 40k cycles
  initial begin
    #4_000_000;
    err_count++;
    final_report();
  end
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(27057));
    inlet = 8'($urandom_range(8'h30));
    tick(6);
    rst = 1'b0;
    tick(2);
    chk(ot_lim, 8'h64);
    chk({7'h00, al}, 8'h00);
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      wr(alert_pkg::CMD_OT_WARN, d);
      chk(ot_lim, d);
      wr(alert_pkg::CMD_OT_WARN, ~d, 1'b1);
      chk(ot_lim, d);
      i_host.xfer(7'h18, alert_pkg::CMD_OC_WARN, d, 1'b1, 1'b0, ack);
      chk({7'h00, ack}, 8'h00);
      chk(oc_lim, 8'hFF);
    end
    wr(alert_pkg::CMD_OC_WARN, 8'h3C);
    pon = 1'b0;
    tick(4);
    pon = 1'b1;
    tick(8);
    chk(oc_lim, 8'hFF);
    wr(alert_pkg::CMD_OT_WARN, 8'h11);
    vin_ok = 1'b0;
    tick(4);
    vin_ok = 1'b1;
    tick(8);
    chk(ot_lim, 8'h64);
    main_on = 1'b1;
    wr(alert_pkg::CMD_PAGE, alert_pkg::PAGE_ALL);
    chk({7'h00, al}, 8'h01);
    clr();
    chk({7'h00, al}, 8'h00);
    oc_wrn = 1'b1;
    tick(3000);
    chk({7'h00, al}, 8'h00);
    oc_wrn = 1'b0;
    clr();
    // Pass 0 clears the whole device, pass 1 clears single bits on page 01h
    for (int k = 0; k < 2; k++) begin
      wr(alert_pkg::CMD_PAGE, k ? 8'h01 : alert_pkg::PAGE_ALL);
      op_wrn = 1'b1;
      wait_al(4000);
      chk({7'h00, n >= alert_pkg::OP_CYC - 3 && n < 4000}, 8'h01);
      if (k == 0) clr();
      else wr(alert_pkg::CMD_ST_IOUT, 8'h01);
      chk({7'h00, al}, 8'h01);
      op_wrn = 1'b0;
      wr(alert_pkg::CMD_ST_IOUT, 8'h20);
      chk({7'h00, al}, 8'h01);
      if (k == 0) clr();
      else wr(alert_pkg::CMD_ST_IOUT, 8'h01);
      tick(2);
      chk({7'h00, al}, 8'h00);
    end
    wr(alert_pkg::CMD_MASK, 8'hFF);
    op_wrn = 1'b1;
    tick(2500);
    chk({7'h00, al}, 8'h00);
    wr(alert_pkg::CMD_MASK, alert_pkg::MASK_ME_IOUT);
    wait_al(20);
    chk({7'h00, al}, 8'h01);
    wr(alert_pkg::CMD_PAGE, alert_pkg::PAGE_ALL);
    main_on = 1'b0;
    op_wrn = 1'b1;
    tick(2500);
    chk({7'h00, al}, 8'h00);
    main_on = 1'b1;
    wait_al(2200);
    chk({7'h00, al}, 8'h01);
    op_wrn = 1'b0;
    clr();
    vin_uv = 1'b1;
    wait_al(40000);
    chk({7'h00, al}, 8'h01);
    vin_uv = 1'b0;
    clr();
    hot = 8'h65 + 8'($urandom_range(30));
    wait_al(5000);
    chk({7'h00, al}, 8'h01);
    hot = 8'h30;
    clr();
    chk({7'h00, al}, 8'h00);
    final_report();
  end
endmodule : test_psu_alert

// ==== hdl/alert_pkg.sv ====
// Package: constants, commands and timing for the status and alert logic
// Function
// - Clearing keeps bit set while event persists
// - Writing one clears only that bit
// - Clear faults clears page, FFh clears all
// - Input power off one second zeroes status
// - Unpowered supply keeps bits until power returns
// - Limits revert on power or request cycling
// - Packet error checking per bus revision 2.0
// - Capability reports PEC, 100 kHz, alert support
// - Revision query returns 22h
// - Profile query returns 05h
// - Inlet or hotspot over limit sets warning
// - Default alerts: UV, OC, OT, OP warnings
// - Input loss alerts within 2 ms above 10%
// - Overcurrent alert delay 10 to 20 ms
// - Overcurrent alert held at most 30 s; an unmasked page 00h latched bit holds the alert past 30 s
// - Hotspot warning alerts within one second
// - Outputs stay good one second after OT alert
// - Overpower alert delay at least 100 us
// - Alert only while main outputs on
// - Mask bit one suppresses event, reads back
// - Masks only through paged PEC transactions
// - Only root event bits drive alert
// - No alert response address; keep own address
// - Status bits latch until a permitted clear
// - Alert follows unmasked events, level sensitive
// - Page 00h board controller, 01h engine
package alert_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned UV_ALERT_US   = 2_000;
  localparam int unsigned OC_ALERT_US   = 10_000;
  localparam int unsigned OC_HOLD_S     = 30;
  localparam int unsigned OP_ALERT_US   = 100;
  localparam int unsigned VIN_OFF_MS    = 1_000;
  localparam int unsigned UV_CYC        = (CLK_HZ / 1_000_000) * UV_ALERT_US / 2;
  localparam int unsigned OC_CYC        = (CLK_HZ / 1_000_000) * OC_ALERT_US;
  localparam int unsigned OP_CYC        = (CLK_HZ / 1_000_000) * OP_ALERT_US;
  localparam int unsigned OC_HOLD_CYC   = CLK_HZ * OC_HOLD_S;
  localparam int unsigned VIN_OFF_CYC   = (CLK_HZ / 1_000) * VIN_OFF_MS;
  localparam int unsigned CNT_W         = 32;

  // ==========================================================
  // Commands
  localparam logic [7:0] CMD_PAGE       = 8'h00;
  localparam logic [7:0] CMD_CLEAR      = 8'h03;
  localparam logic [7:0] CMD_PAGE_WR    = 8'h05;
  localparam logic [7:0] CMD_PAGE_RD    = 8'h06;
  localparam logic [7:0] CMD_CAPAB      = 8'h19;
  localparam logic [7:0] CMD_MASK       = 8'h1B;
  localparam logic [7:0] CMD_ST_IOUT    = 8'h7B;
  localparam logic [7:0] CMD_ST_INPUT   = 8'h7C;
  localparam logic [7:0] CMD_ST_TEMP    = 8'h7D;
  localparam logic [7:0] CMD_OT_WARN    = 8'h51;
  localparam logic [7:0] CMD_OC_WARN    = 8'h4A;
  localparam logic [7:0] CMD_TMAX1      = 8'hC0;
  localparam logic [7:0] CMD_TMAX2      = 8'hC1;
  localparam logic [7:0] CMD_REVISION   = 8'h98;
  localparam logic [7:0] CMD_PROFILE    = 8'h9F;
  localparam logic [7:0] PAGE_ALL       = 8'hFF;
  localparam logic [1:0] NPAGE          = 2'h2;

  // ==========================================================
  // Read-only answers
  localparam logic [7:0] CAPAB_VAL      = 8'h90;
  localparam logic [7:0] REVISION_VAL   = 8'h22;
  localparam logic [7:0] PROFILE_VAL    = 8'h05;

  // ==========================================================
  // Status bit positions and limit defaults
  localparam int unsigned B_OC_FLT      = 7;
  localparam int unsigned B_OC_WRN      = 5;
  localparam int unsigned B_OP_WRN      = 0;
  localparam int unsigned B_UV_FLT      = 4;
  localparam int unsigned B_OT_WRN      = 6;
  localparam logic [7:0] TMAX1_DEF      = 8'h37;
  localparam logic [7:0] TMAX2_DEF      = 8'h64;
  localparam logic [7:0] ZERO8          = 8'h00;
  localparam logic [7:0] ONES8          = 8'hFF;
  localparam logic [7:0] MASK_DEF_IOUT  = 8'hFF;
  localparam logic [7:0] MASK_ME_IOUT   = 8'hDE;
  localparam logic [7:0] MASK_ME_INPUT  = 8'hEF;
  localparam logic [7:0] MASK_ME_TEMP   = 8'hBF;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_CMD,
    BUS_DATA
  } bus_state_t;

endpackage : alert_pkg

// ==== hdl/psu_alert.sv ====
// Top: status latching, paged masks, limits and alert line
`timescale 1ns/1ps
module psu_alert (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_oe,
  input  wire logic       vin_ok,
  input  wire logic       vin_uv,
  input  wire logic       iout_oc_flt,
  input  wire logic       iout_oc_wrn,
  input  wire logic       pout_op_wrn,
  input  wire logic [7:0] inlet_temp_sensor,
  input  wire logic [7:0] hotspot_temp_sensor,
  input  wire logic       power_on_request,
  input  wire logic       main_on,
  output logic            alert_n_oe,
  output logic [7:0]      ot_warn_limit,
  output logic [7:0]      oc_warn_limit
);

  status_bus_if bus ();
  logic sda_oe_w;

  smbus_slave u_link (
    .mclk   (mclk),
    .rst    (rst),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .sda_oe (sda_oe_w),
    .bus    (bus)
  );

  // ==========================================================
  // Event synchronisers
  logic [1:0] s0_q, s1_q, s2_q, s3_q, s4_q, s5_q, s6_q;
  always_ff @(posedge mclk) begin
    s0_q <= {s0_q[0], vin_ok};
    s1_q <= {s1_q[0], vin_uv};
    s2_q <= {s2_q[0], iout_oc_flt};
    s3_q <= {s3_q[0], iout_oc_wrn};
    s4_q <= {s4_q[0], pout_op_wrn};
    s5_q <= {s5_q[0], power_on_request};
    s6_q <= {s6_q[0], main_on};
  end
  logic [7:0] t1_q, t2_q, t1s_q, t2s_q;
  always_ff @(posedge mclk) begin
    t1_q <= inlet_temp_sensor;
    t2_q <= hotspot_temp_sensor;
    t1s_q <= t1_q;
    t2s_q <= t2_q;
  end

  // ==========================================================
  // Power tracking: input off one second arms a clear on return
  logic [31:0] off_q, off_d;
  logic        arm_q, arm_d, pon_p_q, vin_p_q, lim_rst, pwr_clr;
  always_comb begin
    off_d = s0_q[1] ? 32'h0 : (off_q < alert_pkg::VIN_OFF_CYC ? off_q + 32'h1 : off_q);
    arm_d = arm_q;
    if (!s0_q[1] && off_q >= alert_pkg::VIN_OFF_CYC - 1) arm_d = 1'b1;
    if (s0_q[1]) arm_d = 1'b0;
  end
  // Bits stay untouched while unpowered, zeroed on the return edge
  assign pwr_clr = s0_q[1] & ~vin_p_q & arm_q;
  assign lim_rst = (s0_q[1] & ~vin_p_q) | (s5_q[1] & ~pon_p_q);
  always_ff @(posedge mclk) begin
    if (rst) begin
      off_q <= 32'h0; arm_q <= 1'b0; pon_p_q <= 1'b0; vin_p_q <= 1'b1;
    end else begin
      off_q <= off_d; arm_q <= arm_d; pon_p_q <= s5_q[1]; vin_p_q <= s0_q[1];
    end
  end

  // ==========================================================
  // Limits and qualified events
  logic [7:0] tmax1_q, tmax1_d, tmax2_q, tmax2_d, otl_q, otl_d, ocl_q, ocl_d;
  logic [7:0] page_q, page_d;
  wire ot_ev = (t1s_q > tmax1_q) | (t2s_q > tmax2_q) | (t2s_q > otl_q);
  logic [31:0] uv_c_q, oc_c_q, op_c_q, hold_q;
  wire uv_ev = (uv_c_q >= alert_pkg::UV_CYC);
  wire oc_ev = (oc_c_q >= alert_pkg::OC_CYC);
  wire op_ev = (op_c_q >= alert_pkg::OP_CYC);
  always_ff @(posedge mclk) begin
    if (rst) begin
      uv_c_q <= 32'h0; oc_c_q <= 32'h0; op_c_q <= 32'h0; hold_q <= 32'h0;
    end else begin
      uv_c_q <= s1_q[1] ? (uv_ev ? uv_c_q : uv_c_q + 32'h1) : 32'h0;
      oc_c_q <= s3_q[1] ? (oc_ev ? oc_c_q : oc_c_q + 32'h1) : 32'h0;
      op_c_q <= s4_q[1] ? (op_ev ? op_c_q : op_c_q + 32'h1) : 32'h0;
      // Page 01h overcurrent alert contribution lapses after the hold window; page 00h keeps its latched bit
      hold_q <= oc_ev ? (hold_q < alert_pkg::OC_HOLD_CYC ? hold_q + 32'h1 : hold_q) : 32'h0;
    end
  end
  wire oc_live = oc_ev & (hold_q < alert_pkg::OC_HOLD_CYC);

  wire [7:0] ev_iout  = ({7'h0, s2_q[1]} << alert_pkg::B_OC_FLT)
                      | ({7'h0, oc_ev} << alert_pkg::B_OC_WRN)
                      | ({7'h0, op_ev} << alert_pkg::B_OP_WRN);
  wire [7:0] ev_input = {7'h0, uv_ev} << alert_pkg::B_UV_FLT;
  wire [7:0] ev_temp  = {7'h0, ot_ev} << alert_pkg::B_OT_WRN;

  // ==========================================================
  // Status and mask registers, index 0 = page 00h, 1 = page 01h, 2 = unpaged
  logic [7:0] st_io_q [3], st_in_q [3], st_tp_q [3];
  logic [7:0] st_io_d [3], st_in_d [3], st_tp_d [3];
  logic [7:0] mk_io_q [2], mk_in_q [2], mk_tp_q [2];
  logic [7:0] mk_io_d [2], mk_in_d [2], mk_tp_d [2];

  function automatic logic page_hit(input logic [7:0] pg, input int idx);
    return (pg == alert_pkg::PAGE_ALL) || (idx == 2) || (pg == 8'(idx));
  endfunction : page_hit

  wire wr_ok = bus.wr_stb & bus.pec_ok;
  generate
    for (genvar i = 0; i < 3; i++) begin : g_st
      always_comb begin
        logic clr_all;
        clr_all = pwr_clr | (bus.clr_stb & page_hit(page_q, i));
        st_io_d[i] = st_io_q[i];
        st_in_d[i] = st_in_q[i];
        st_tp_d[i] = st_tp_q[i];
        if (clr_all) begin
          st_io_d[i] = alert_pkg::ZERO8;
          st_in_d[i] = alert_pkg::ZERO8;
          st_tp_d[i] = alert_pkg::ZERO8;
        end else if (wr_ok && page_hit(page_q, i)) begin
          if (bus.wr_cmd == alert_pkg::CMD_ST_IOUT)  st_io_d[i] = st_io_q[i] & ~bus.wr_data;
          if (bus.wr_cmd == alert_pkg::CMD_ST_INPUT) st_in_d[i] = st_in_q[i] & ~bus.wr_data;
          if (bus.wr_cmd == alert_pkg::CMD_ST_TEMP)  st_tp_d[i] = st_tp_q[i] & ~bus.wr_data;
        end
        // Present events win over any clear so the bit never drops
        st_io_d[i] = st_io_d[i] | ev_iout;
        st_in_d[i] = st_in_d[i] | ev_input;
        st_tp_d[i] = st_tp_d[i] | ev_temp;
      end
      always_ff @(posedge mclk) begin
        if (rst) begin
          st_io_q[i] <= alert_pkg::ZERO8;
          st_in_q[i] <= alert_pkg::ZERO8;
          st_tp_q[i] <= alert_pkg::ZERO8;
        end else begin
          st_io_q[i] <= st_io_d[i];
          st_in_q[i] <= st_in_d[i];
          st_tp_q[i] <= st_tp_d[i];
        end
      end
    end
    for (genvar p = 0; p < 2; p++) begin : g_mk
      always_comb begin
        mk_io_d[p] = mk_io_q[p];
        mk_in_d[p] = mk_in_q[p];
        mk_tp_d[p] = mk_tp_q[p];
        // Masks are written only through the paged mask command with PEC
        if (wr_ok && page_q == 8'(p) && bus.wr_cmd == alert_pkg::CMD_MASK) begin
          mk_io_d[p] = bus.wr_data;
        end
      end
      always_ff @(posedge mclk) begin
        if (rst) begin
          mk_io_q[p] <= (p == 1) ? alert_pkg::MASK_ME_IOUT : alert_pkg::MASK_DEF_IOUT;
          mk_in_q[p] <= (p == 1) ? alert_pkg::MASK_ME_INPUT : alert_pkg::ONES8;
          mk_tp_q[p] <= (p == 1) ? alert_pkg::MASK_ME_TEMP : alert_pkg::ONES8;
        end else begin
          mk_io_q[p] <= mk_io_d[p];
          mk_in_q[p] <= mk_in_d[p];
          mk_tp_q[p] <= mk_tp_d[p];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Page and limit registers
  always_comb begin
    page_d = page_q; tmax1_d = tmax1_q; tmax2_d = tmax2_q; otl_d = otl_q; ocl_d = ocl_q;
    if (wr_ok) begin
      case (bus.wr_cmd)
        alert_pkg::CMD_PAGE, alert_pkg::CMD_PAGE_WR: page_d = bus.wr_data;
        alert_pkg::CMD_TMAX1:  tmax1_d = bus.wr_data;
        alert_pkg::CMD_TMAX2:  tmax2_d = bus.wr_data;
        alert_pkg::CMD_OT_WARN: otl_d = bus.wr_data;
        alert_pkg::CMD_OC_WARN: ocl_d = bus.wr_data;
        default: ;
      endcase
    end
    if (lim_rst) begin
      tmax1_d = alert_pkg::TMAX1_DEF; tmax2_d = alert_pkg::TMAX2_DEF;
      otl_d = alert_pkg::TMAX2_DEF; ocl_d = alert_pkg::ONES8;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      page_q <= alert_pkg::ZERO8; tmax1_q <= alert_pkg::TMAX1_DEF;
      tmax2_q <= alert_pkg::TMAX2_DEF; otl_q <= alert_pkg::TMAX2_DEF; ocl_q <= alert_pkg::ONES8;
    end else begin
      page_q <= page_d; tmax1_q <= tmax1_d; tmax2_q <= tmax2_d; otl_q <= otl_d; ocl_q <= ocl_d;
    end
  end

  // ==========================================================
  // Read mux
  wire [1:0] pix = (page_q == 8'h01) ? 2'h1 : (page_q == 8'h00 ? 2'h0 : alert_pkg::NPAGE);
  always_comb begin
    case (bus.rd_cmd)
      alert_pkg::CMD_CAPAB:    bus.rd_data = alert_pkg::CAPAB_VAL;
      alert_pkg::CMD_REVISION: bus.rd_data = alert_pkg::REVISION_VAL;
      alert_pkg::CMD_PROFILE:  bus.rd_data = alert_pkg::PROFILE_VAL;
      alert_pkg::CMD_ST_IOUT:  bus.rd_data = st_io_q[pix];
      alert_pkg::CMD_ST_INPUT: bus.rd_data = st_in_q[pix];
      alert_pkg::CMD_ST_TEMP:  bus.rd_data = st_tp_q[pix];
      alert_pkg::CMD_MASK:     bus.rd_data = mk_io_q[pix[0]];
      alert_pkg::CMD_PAGE:     bus.rd_data = page_q;
      alert_pkg::CMD_TMAX1:    bus.rd_data = tmax1_q;
      alert_pkg::CMD_TMAX2:    bus.rd_data = tmax2_q;
      default:                 bus.rd_data = alert_pkg::ZERO8;
    endcase
  end

  // ==========================================================
  // Alert: root bits only, through page masks, gated by main outputs
  logic alert_q, sda_q;
  logic [7:0] otl_o_q, ocl_o_q;
  logic [7:0] root_io;
  always_comb begin
    root_io = st_io_q[0] | st_io_q[1];
    root_io[alert_pkg::B_OC_WRN] = (st_io_q[0][alert_pkg::B_OC_WRN] & ~mk_io_q[0][alert_pkg::B_OC_WRN])
                                 | (oc_live & ~mk_io_q[1][alert_pkg::B_OC_WRN]);
  end
  wire any_ev = |((st_io_q[0] & ~mk_io_q[0]) | (st_io_q[1] & ~mk_io_q[1]) & ~8'h20)
              | (|root_io[alert_pkg::B_OC_WRN:alert_pkg::B_OC_WRN])
              | |((st_in_q[0] & ~mk_in_q[0]) | (st_in_q[1] & ~mk_in_q[1]))
              | |((st_tp_q[0] & ~mk_tp_q[0]) | (st_tp_q[1] & ~mk_tp_q[1]));
  always_ff @(posedge mclk) begin
    if (rst) begin
      alert_q <= 1'b0; sda_q <= 1'b0; otl_o_q <= alert_pkg::TMAX2_DEF; ocl_o_q <= alert_pkg::ONES8;
    end else begin
      alert_q <= any_ev & s6_q[1];
      sda_q <= sda_oe_w;
      otl_o_q <= otl_q;
      ocl_o_q <= ocl_q;
    end
  end
  // Outputs are not touched by this block after an OT alert, keeping regulation
  assign alert_n_oe    = alert_q;
  assign sda_oe        = sda_q;
  assign ot_warn_limit = otl_o_q;
  assign oc_warn_limit = ocl_o_q;

endmodule : psu_alert

// ==== hdl/smbus_slave.sv ====
// Byte-level SMBus slave with packet error checking
`timescale 1ns/1ps
module smbus_slave #(
  parameter logic [6:0] ADDR = 7'h58
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_oe,
  status_bus_if.link       bus
);

  // ==========================================================
  // Pin synchronisers and edge detection
  logic [1:0] scl_s_q, sda_s_q;
  logic       scl_p_q, sda_p_q;
  always_ff @(posedge mclk) begin
    scl_s_q <= {scl_s_q[0], scl_in};
    sda_s_q <= {sda_s_q[0], sda_in};
    scl_p_q <= scl_s_q[1];
    sda_p_q <= sda_s_q[1];
  end
  wire scl = scl_s_q[1];
  wire sda = sda_s_q[1];
  wire scl_rise = scl & ~scl_p_q;
  wire scl_fall = ~scl & scl_p_q;
  // SCL must have been high a full cycle: our own delayed SDA change landing
  // with the SCL rise in the synchronisers is not a bus condition
  wire start = scl & scl_p_q & sda_p_q & ~sda;
  wire stop  = scl & scl_p_q & ~sda_p_q & sda;

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
    return r;
  endfunction : crc8

  // ==========================================================
  // Shift engine
  logic [7:0] sh_q, sh_d, crc_q, crc_d, cmd_q, cmd_d, dat_q, dat_d, tx_q, tx_d;
  logic [3:0] bit_q, bit_d;
  logic [2:0] byt_q, byt_d;
  logic       ack_q, ack_d, rd_q, rd_d, oe_q, oe_d, hit_q, hit_d;
  logic       wr_d, clr_d;
  alert_pkg::bus_state_t st_q, st_d;

  always_comb begin
    sh_d = sh_q; crc_d = crc_q; cmd_d = cmd_q; dat_d = dat_q; tx_d = tx_q;
    bit_d = bit_q; byt_d = byt_q; ack_d = ack_q; rd_d = rd_q; oe_d = oe_q;
    hit_d = hit_q; st_d = st_q; wr_d = 1'b0; clr_d = 1'b0;
    if (start) begin
      st_d = alert_pkg::BUS_CMD; bit_d = 4'h0; byt_d = 3'h0; oe_d = 1'b0;
      ack_d = 1'b0; hit_d = 1'b0; crc_d = alert_pkg::ZERO8;
    end else if (stop) begin
      // Send-byte clear with or without PEC, or write with a good PEC byte
      if (hit_q && !rd_q && cmd_q == alert_pkg::CMD_CLEAR &&
          (byt_q == 3'h2 || (byt_q == 3'h3 && crc_q == alert_pkg::ZERO8))) clr_d = 1'b1;
      if (hit_q && !rd_q && byt_q == 3'h4 && crc_q == alert_pkg::ZERO8) begin
        if (cmd_q == alert_pkg::CMD_CLEAR) clr_d = 1'b1;
        else wr_d = 1'b1;
      end
      st_d = alert_pkg::BUS_IDLE; oe_d = 1'b0;
    end else if (st_q != alert_pkg::BUS_IDLE && scl_rise && !ack_q && !(rd_q && byt_q != 3'h0)) begin
      sh_d = {sh_q[6:0], sda}; bit_d = bit_q + 4'h1;
    end else if (st_q != alert_pkg::BUS_IDLE && scl_fall) begin
      if (ack_q) begin
        ack_d = 1'b0; oe_d = 1'b0; bit_d = 4'h0;
        if (rd_q && byt_q != 3'h0) begin
          oe_d = ~tx_q[7];
        end
      end else if (rd_q && byt_q != 3'h0) begin
        if (bit_q == 4'h7) begin
          oe_d = 1'b0; bit_d = 4'h0; tx_d = crc8(crc_q, dat_q); crc_d = crc8(crc_q, dat_q);
          dat_d = tx_d; byt_d = byt_q + 3'h1;
          if (byt_q > 3'h2) st_d = alert_pkg::BUS_IDLE;
        end else begin
          tx_d = {tx_q[6:0], 1'b0}; oe_d = ~tx_q[6]; bit_d = bit_q + 4'h1;
        end
      end else if (bit_q == 4'h8) begin
        crc_d = crc8(crc_q, sh_q);
        if (byt_q == 3'h0) begin
          // Only the own address is acknowledged; 18h is never answered
          hit_d = (sh_q[7:1] == ADDR);
          rd_d = sh_q[0]; ack_d = hit_d; oe_d = hit_d;
          if (!hit_d) st_d = alert_pkg::BUS_IDLE;
          if (sh_q[0] && hit_d) begin
            tx_d = bus.rd_data; dat_d = bus.rd_data; byt_d = 3'h1;
          end else byt_d = 3'h1;
        end else begin
          ack_d = 1'b1; oe_d = 1'b1; byt_d = byt_q + 3'h1;
          if (byt_q == 3'h1) cmd_d = sh_q;
          if (byt_q == 3'h2) dat_d = sh_q;
        end
      end
    end
    if (rd_q && byt_q != 3'h0 && st_q != alert_pkg::BUS_IDLE && scl_rise && !ack_q && bit_q == 4'h8)
      st_d = sda ? alert_pkg::BUS_IDLE : st_q;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= alert_pkg::BUS_IDLE; sh_q <= 8'h00; crc_q <= 8'h00; cmd_q <= 8'h00;
      dat_q <= 8'h00; tx_q <= 8'h00; bit_q <= 4'h0; byt_q <= 3'h0; ack_q <= 1'b0;
      rd_q <= 1'b0; oe_q <= 1'b0; hit_q <= 1'b0;
    end else begin
      st_q <= st_d; sh_q <= sh_d; crc_q <= crc_d; cmd_q <= cmd_d; dat_q <= dat_d;
      tx_q <= tx_d; bit_q <= bit_d; byt_q <= byt_d; ack_q <= ack_d; rd_q <= rd_d;
      oe_q <= oe_d; hit_q <= hit_d;
    end
  end

  assign sda_oe      = oe_q;
  assign bus.wr_stb  = wr_d;
  assign bus.clr_stb = clr_d;
  assign bus.wr_cmd  = cmd_q;
  assign bus.wr_data = dat_q;
  assign bus.rd_cmd  = cmd_q;
  assign bus.pec_ok  = (crc_q == alert_pkg::ZERO8);

endmodule : smbus_slave

// ==== hdl/status_bus_if.sv ====
// Interface carrying decoded bus transactions to the status core
`timescale 1ns/1ps
interface status_bus_if;
  logic       wr_stb;
  logic [7:0] wr_cmd;
  logic [7:0] wr_data;
  logic       clr_stb;
  logic [7:0] rd_cmd;
  logic [7:0] rd_data;
  logic       pec_ok;

  modport link (output wr_stb, output wr_cmd, output wr_data, output clr_stb,
                output rd_cmd, output pec_ok, input rd_data);
  modport core (input wr_stb, input wr_cmd, input wr_data, input clr_stb,
                input rd_cmd, input pec_ok, output rd_data);
endinterface : status_bus_if
